// File: inc/pmc_pkg.sv
// Package for the power-mode controller: register map, fields, timing.
// Assumes a single 25 MHz system clock and an APB slave with 32-bit data.

package pmc_pkg;

   // Operating modes of the core
   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_SLOW,
      PMC_WAIT,
      PMC_HALT,
      PMC_STOP,
      PMC_WAKE
   } pmc_mode_t;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFS    = 12'h000;
   localparam logic [11:0] STATUS_OFS  = 12'h004;
   localparam logic [11:0] WAITDIV_OFS = 12'h008;
   localparam logic [11:0] STARTUP_OFS = 12'h00C;

   // Control field positions
   localparam int CTRL_SLOW_BIT  = 0;
   localparam int CTRL_SRC_LSB   = 1;
   localparam int CTRL_DIV_LSB   = 4;
   localparam int CTRL_DIV_W     = 4;

   // Clock source selection codes
   localparam logic [1:0] SRC_PLL = 2'h0;
   localparam logic [1:0] SRC_OSC = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;

   // Reset values
   localparam logic [31:0] CTRL_RST    = 32'h0000_0030;
   localparam logic [3:0]  WAITDIV_RST = 4'hF;

   // Oscillator start-up time after stop, and cycles at 25 MHz
   localparam int CLK_MHZ         = 25;
   localparam int OSC_STARTUP_US  = 100;
   localparam int OSC_STARTUP_CYC = OSC_STARTUP_US * CLK_MHZ;
   localparam logic [15:0] STARTUP_RST = 16'(OSC_STARTUP_CYC);

endpackage : pmc_pkg

// File: verilog/pmc_top.sv
// Power-mode controller: run, slow, wait-for-irq, halt and stop sequencing.
// Assumes a CPU that pulses mode requests and an APB master for registers.

`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: Wait-for-irq suspends execution until an interrupt acknowledge arrives.
// R2: Wait-for-irq stops CPU clock, keeps irq logic at programmed rate.
// R3: Halt with watchdog off stops CPU and peripherals.
// R4: Halt with watchdog on is ignored; run continues.
// R5: Halt is left only through reset.
// R6: Stop halts CPU and peripherals until a wake-up line rises.
// R7: Stop keeps register state; exit continues without reset.
// R8: Watchdog counter is frozen during stop, resumes afterward.
// R9: Leaving stop waits an oscillator start-up count before clocks return.
// R10: Slow mode clocks CPU and peripherals at a divided rate.
// R11: Run mode clocks at full speed from PLL, oscillator or external.
// R12: Reset is held while the low-voltage detector reports low supply.
// R13: One mode state, forced to run by any reset.
module pmc_top (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   // Reset sources
   input  wire logic        low_voltage_detector_i,
   input  wire logic        ext_reset_n_i,
   // CPU requests and watchdog state
   input  wire logic        wait_req_i,
   input  wire logic        halt_req_i,
   input  wire logic        stop_req_i,
   input  wire logic        wdg_enable_i,
   input  wire logic        irq_ack_i,
   input  wire logic [3:0]  wakeup_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Clock enables and controls
   output logic             cpu_clk_en_o,
   output logic             per_clk_en_o,
   output logic             irq_clk_en_o,
   output logic      [1:0]  clk_src_o,
   output logic             wdg_freeze_o,
   output logic             sys_reset_o,
   output logic      [2:0]  mode_o
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      pmc_pkg::pmc_mode_t mode;
      logic               slow;
      logic [1:0]         src;
      logic [3:0]         div;
      logic [3:0]         waitdiv;
      logic [15:0]        startup;
      logic [15:0]        cnt;
      logic [3:0]         div_cnt;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               cpu_en;
      logic               per_en;
      logic               irq_en;
      logic               freeze;
      logic               sysrst;
   } pmc_state_t;

   pmc_state_t st_reg;
   pmc_state_t st_next;

   // Internal reset from any source, held while supply is low
   logic any_reset;
   assign any_reset = low_voltage_detector_i | ~ext_reset_n_i; // R12

   // Decodes an APB offset to a register index, 7 when unmapped
   function automatic logic [2:0] reg_index(input logic [11:0] a);
      case (a)
         pmc_pkg::CTRL_OFS:    reg_index = 3'h0;
         pmc_pkg::STATUS_OFS:  reg_index = 3'h1;
         pmc_pkg::WAITDIV_OFS: reg_index = 3'h2;
         pmc_pkg::STARTUP_OFS: reg_index = 3'h3;
         default:              reg_index = 3'h7;
      endcase
   endfunction : reg_index

   logic       access;
   logic [2:0] idx;
   logic       tick;
   logic       div_hit;
   assign access = psel_i & penable_i & ~st_reg.pready;
   assign idx    = reg_index(paddr_i);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Divider tick: shared by slow and wait-for-irq rates
   always_comb begin
      logic [3:0] lim;
      lim = (st_reg.mode == pmc_pkg::PMC_WAIT) ? st_reg.waitdiv : st_reg.div;
      div_hit = (st_reg.div_cnt >= lim);
      tick    = div_hit;
   end

   always_comb begin
      st_next = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.div_cnt = div_hit ? 4'h0 : st_reg.div_cnt + 4'h1;

      // APB access, answered after one wait state in the access phase
      if (access) begin
         st_next.pready = 1'b1;
         st_next.pslverr = (idx == 3'h7);
         st_next.prdata = 32'h0000_0000;
         if (pwrite_i) begin
            case (idx)
               3'h0: begin
                  st_next.slow = pwdata_i[pmc_pkg::CTRL_SLOW_BIT];
                  st_next.src  = pwdata_i[pmc_pkg::CTRL_SRC_LSB +: 2];
                  st_next.div  = pwdata_i[pmc_pkg::CTRL_DIV_LSB +:
                                          pmc_pkg::CTRL_DIV_W];
               end
               3'h2: st_next.waitdiv = pwdata_i[3:0];
               3'h3: st_next.startup = pwdata_i[15:0];
               default: ;
            endcase
         end else begin
            case (idx)
               3'h0: st_next.prdata = {24'h0, st_reg.div, 1'b0,
                                       st_reg.src, st_reg.slow};
               3'h1: st_next.prdata = {12'h0, st_reg.cnt, 1'b0,
                                       st_reg.mode};
               3'h2: st_next.prdata = {28'h0, st_reg.waitdiv};
               3'h3: st_next.prdata = {16'h0, st_reg.startup};
               default: st_next.prdata = 32'h0000_0000;
            endcase
         end
      end

      // Mode sequencing
      // Halt beats stop beats wait; requests in other modes are dropped
      case (st_reg.mode)
         pmc_pkg::PMC_RUN, pmc_pkg::PMC_SLOW: begin
            st_next.mode = st_next.slow ? pmc_pkg::PMC_SLOW
                                        : pmc_pkg::PMC_RUN; // R10 R11
            if (halt_req_i && !wdg_enable_i)
               st_next.mode = pmc_pkg::PMC_HALT; // R3 R4
            else if (stop_req_i)
               st_next.mode = pmc_pkg::PMC_STOP; // R6
            else if (wait_req_i)
               st_next.mode = pmc_pkg::PMC_WAIT; // R1
         end
         pmc_pkg::PMC_WAIT:
            if (irq_ack_i)
               st_next.mode = st_reg.slow ? pmc_pkg::PMC_SLOW
                                          : pmc_pkg::PMC_RUN; // R1
         pmc_pkg::PMC_HALT: ; // R5
         pmc_pkg::PMC_STOP:
            if (|wakeup_i) begin
               st_next.mode = pmc_pkg::PMC_WAKE; // R6
               st_next.cnt  = st_reg.startup; // R9
            end
         pmc_pkg::PMC_WAKE:
            if (st_reg.cnt <= 16'h0001)
               st_next.mode = st_reg.slow ? pmc_pkg::PMC_SLOW
                                          : pmc_pkg::PMC_RUN; // R7 R9
            else
               st_next.cnt = st_reg.cnt - 16'h0001; // R9
         default: st_next.mode = pmc_pkg::PMC_RUN;
      endcase

      // Clock enables from the next mode
      case (st_next.mode)
         pmc_pkg::PMC_RUN: begin
            st_next.cpu_en = 1'b1; // R11
            st_next.per_en = 1'b1;
            st_next.irq_en = 1'b1;
         end
         pmc_pkg::PMC_SLOW: begin
            st_next.cpu_en = tick; // R10
            st_next.per_en = tick;
            st_next.irq_en = tick;
         end
         pmc_pkg::PMC_WAIT: begin
            st_next.cpu_en = 1'b0; // R2
            st_next.per_en = tick;
            st_next.irq_en = tick;
         end
         default: begin
            st_next.cpu_en = 1'b0; // R3 R6 R9
            st_next.per_en = 1'b0;
            st_next.irq_en = 1'b0;
         end
      endcase
      st_next.freeze = (st_next.mode == pmc_pkg::PMC_STOP ||
                        st_next.mode == pmc_pkg::PMC_WAKE) &&
                       wdg_enable_i; // R8
      st_next.sysrst = 1'b0;

      // Any reset forces run; control registers reinitialised
      if (any_reset) begin
         st_next = '0;
         st_next.mode    = pmc_pkg::PMC_RUN; // R13
         st_next.slow    = pmc_pkg::CTRL_RST[pmc_pkg::CTRL_SLOW_BIT];
         st_next.div     = pmc_pkg::CTRL_RST[pmc_pkg::CTRL_DIV_LSB +:
                                             pmc_pkg::CTRL_DIV_W];
         st_next.waitdiv = pmc_pkg::WAITDIV_RST;
         st_next.startup = pmc_pkg::STARTUP_RST;
         st_next.sysrst  = 1'b1; // R5 R12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; async reset takes constants only

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg         <= '0;
         st_reg.mode    <= pmc_pkg::PMC_RUN; // R13
         st_reg.slow    <= pmc_pkg::CTRL_RST[pmc_pkg::CTRL_SLOW_BIT];
         st_reg.div     <= pmc_pkg::CTRL_RST[pmc_pkg::CTRL_DIV_LSB +:
                                             pmc_pkg::CTRL_DIV_W];
         st_reg.waitdiv <= pmc_pkg::WAITDIV_RST;
         st_reg.startup <= pmc_pkg::STARTUP_RST;
         st_reg.sysrst  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops
   assign prdata_o     = st_reg.prdata;
   assign pready_o     = st_reg.pready;
   assign pslverr_o    = st_reg.pslverr;
   assign cpu_clk_en_o = st_reg.cpu_en;
   assign per_clk_en_o = st_reg.per_en;
   assign irq_clk_en_o = st_reg.irq_en;
   assign clk_src_o    = st_reg.src;
   assign wdg_freeze_o = st_reg.freeze;
   assign sys_reset_o  = st_reg.sysrst;
   assign mode_o       = st_reg.mode;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   a_wait_irq_ack: assert property ( // R1
      st_reg.mode == pmc_pkg::PMC_WAIT && !irq_ack_i && !any_reset
      |=> st_reg.mode == pmc_pkg::PMC_WAIT)
      else $error("wait mode left without acknowledge");
   a_wait_cpu_off: assert property ( // R2
      st_reg.mode == pmc_pkg::PMC_WAIT |-> !cpu_clk_en_o)
      else $error("cpu clock running in wait mode");
   a_halt_entry: assert property ( // R3
      (st_reg.mode == pmc_pkg::PMC_RUN) && halt_req_i && !wdg_enable_i
      && !any_reset |=> st_reg.mode == pmc_pkg::PMC_HALT && !per_clk_en_o)
      else $error("halt not entered");
   a_halt_ignored: assert property ( // R4
      st_reg.mode == pmc_pkg::PMC_RUN && halt_req_i && wdg_enable_i
      |=> st_reg.mode != pmc_pkg::PMC_HALT)
      else $error("halt taken with watchdog on");
   a_halt_sticky: assert property ( // R5
      st_reg.mode == pmc_pkg::PMC_HALT && !any_reset
      |=> st_reg.mode == pmc_pkg::PMC_HALT)
      else $error("halt left without reset");
   a_stop_wake: assert property ( // R6
      st_reg.mode == pmc_pkg::PMC_STOP && |wakeup_i && !any_reset
      |=> st_reg.mode == pmc_pkg::PMC_WAKE && !cpu_clk_en_o)
      else $error("wake-up not honoured");
   a_wdg_freeze: assert property ( // R8
      st_reg.mode == pmc_pkg::PMC_STOP && $past(wdg_enable_i)
      |-> wdg_freeze_o)
      else $error("watchdog not frozen in stop");
   a_startup_hold: assert property ( // R9
      st_reg.mode == pmc_pkg::PMC_WAKE |-> !cpu_clk_en_o && !per_clk_en_o)
      else $error("clocks released before start-up");
   a_reset_run: assert property ( // R12
      any_reset |=> st_reg.mode == pmc_pkg::PMC_RUN && sys_reset_o)
      else $error("reset did not force run");

   // Clock enables per mode; a reset cycle shows all enables low
   a_run_clocks: assert property ( // R11
      st_reg.mode == pmc_pkg::PMC_RUN && !sys_reset_o
      |-> cpu_clk_en_o && per_clk_en_o && irq_clk_en_o)
      else $error("clocks gated in run mode");
   a_slow_pulse: assert property ( // R10
      st_reg.mode == pmc_pkg::PMC_SLOW && st_reg.div != 4'h0
      && cpu_clk_en_o |=> !cpu_clk_en_o || st_reg.mode != pmc_pkg::PMC_SLOW)
      else $error("slow clock enable longer than one cycle");
   a_halt_clocks: assert property ( // R3
      st_reg.mode == pmc_pkg::PMC_HALT
      |-> !cpu_clk_en_o && !per_clk_en_o && !irq_clk_en_o)
      else $error("clock running in halt");
   a_stop_clocks: assert property ( // R6
      st_reg.mode == pmc_pkg::PMC_STOP
      |-> !cpu_clk_en_o && !per_clk_en_o && !irq_clk_en_o)
      else $error("clock running in stop");
   a_reset_clocks: assert property ( // R12
      sys_reset_o |-> !cpu_clk_en_o && !per_clk_en_o && !irq_clk_en_o)
      else $error("clock running during reset");

   // Stop keeps the control state that software left behind
   a_stop_keeps: assert property ( // R7
      st_reg.mode == pmc_pkg::PMC_STOP && !any_reset && !access
      |=> $stable(st_reg.slow) && $stable(st_reg.src) && $stable(st_reg.div))
      else $error("control state lost in stop");
   a_wake_exit: assert property ( // R7
      st_reg.mode == pmc_pkg::PMC_WAKE && st_reg.cnt <= 16'h0001
      && !any_reset |=> (st_reg.mode == pmc_pkg::PMC_RUN ||
                         st_reg.mode == pmc_pkg::PMC_SLOW) && !sys_reset_o)
      else $error("stop exit not a plain resume");

   // Start-up count: loaded on wake-up, then one step per cycle
   a_wake_load: assert property ( // R9
      st_reg.mode == pmc_pkg::PMC_STOP && |wakeup_i && !any_reset
      |=> st_reg.cnt == $past(st_reg.startup))
      else $error("start-up count not loaded");
   a_wake_count: assert property ( // R9
      st_reg.mode == pmc_pkg::PMC_WAKE && st_reg.cnt > 16'h0001
      && !any_reset |=> st_reg.mode == pmc_pkg::PMC_WAKE
      && st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
      else $error("start-up count skipped");
   a_freeze_only_stop: assert property ( // R8
      st_reg.mode != pmc_pkg::PMC_STOP && st_reg.mode != pmc_pkg::PMC_WAKE
      |-> !wdg_freeze_o)
      else $error("watchdog frozen outside stop");

   c_wait: cover property (st_reg.mode == pmc_pkg::PMC_WAIT ##1 irq_ack_i);
   c_halt_ignored: cover property (st_reg.mode == pmc_pkg::PMC_RUN &&
                                   halt_req_i && wdg_enable_i);
   c_stop: cover property (st_reg.mode == pmc_pkg::PMC_WAKE
                           ##1 st_reg.mode == pmc_pkg::PMC_RUN);
   c_halt: cover property (st_reg.mode == pmc_pkg::PMC_HALT);
   c_slow: cover property (st_reg.mode == pmc_pkg::PMC_SLOW);

endmodule : pmc_top

`default_nettype wire

// File: sim/pmc_cpu_model.sv
// CPU and watchdog model: turns a bench command into mode requests
// and keeps a watchdog count. Assumes the design's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module pmc_cpu_model (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   // Bench command and watchdog state
   input  wire logic        go_i,
   input  wire logic [1:0]  cmd_i,
   input  wire logic        wdg_enable_i,
   input  wire logic        wdg_freeze_i,
   // Requests and watchdog count
   output logic             wait_req_o,
   output logic             halt_req_o,
   output logic             stop_req_o,
   output logic      [15:0] wdg_cnt_o
);
   // Requests last exactly as long as the one-cycle go pulse
   assign wait_req_o = go_i && (cmd_i == 2'h1);
   assign halt_req_o = go_i && (cmd_i == 2'h2);
   assign stop_req_o = go_i && (cmd_i == 2'h3);
   // Holds while frozen, so stop never loses watchdog time
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdg_cnt_o <= 16'h0000;
      end else if (wdg_enable_i && !wdg_freeze_i) begin
         wdg_cnt_o <= wdg_cnt_o + 16'h0001;
      end
   end
endmodule : pmc_cpu_model
`default_nettype wire

// File: sim/pmc_top_tb.sv
// Self-checking bench: mode entries as table rows, then hand cases.
// Assumes the package, the design top and the CPU model.
`timescale 1ns/100ps
`default_nettype none
module pmc_top_tb;
   logic clock_i = 1'b0, arst_n = 1'b0, sup_low = 1'b0, ext_n = 1'b1;
   logic wdg_en = 1'b0, ack = 1'b0, go = 1'b0, err;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr;
   logic [1:0]  cmd = 2'h0, src;
   logic [3:0]  wake = 4'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, prd, rd;
   logic        cpu_en, per_en, irq_en, frz, srst, wait_r, hlt_r, stp_r;
   logic [2:0]  mode;
   logic [15:0] wcnt, w0;
   logic [6:0]  rows [5];
   int          error_cnt = 0, check_count = 0, cyc = 0, n, k;
   ////////////////////////////////////////////////////////////////////
   pmc_top pmc_top_inst (.clock_i(clock_i), .arst_n_i(arst_n),
      .low_voltage_detector_i(sup_low), .ext_reset_n_i(ext_n),
      .wait_req_i(wait_r), .halt_req_i(hlt_r), .stop_req_i(stp_r),
      .wdg_enable_i(wdg_en), .irq_ack_i(ack), .wakeup_i(wake),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .cpu_clk_en_o(cpu_en), .per_clk_en_o(per_en),
      .irq_clk_en_o(irq_en), .clk_src_o(src), .wdg_freeze_o(frz),
      .sys_reset_o(srst), .mode_o(mode));
   pmc_cpu_model pmc_cpu_model_inst (.clock_i(clock_i),
      .arst_n_i(arst_n), .go_i(go), .cmd_i(cmd), .wdg_enable_i(wdg_en),
      .wdg_freeze_i(frz), .wait_req_o(wait_r), .halt_req_o(hlt_r),
      .stop_req_o(stp_r), .wdg_cnt_o(wcnt));
   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt = error_cnt + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   // Waits for pready with no assumed latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
      @(posedge clock_i);
      pen <= 1'b1;
      do @(posedge clock_i); while (prdy !== 1'b1);
      rd = prd;
      err = perr;
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb
   task automatic req(input logic [1:0] c);
      @(posedge clock_i);
      cmd <= c; go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask : req
   task automatic rst();
      @(posedge clock_i);
      arst_n <= 1'b0;
      repeat (5) @(posedge clock_i);
      arst_n <= 1'b1;
      @(posedge clock_i);
   endtask : rst
   ////////////////////////////////////////////////////////////////////
   // Rows: request, watchdog enable, mode, cpu clock enable
   initial begin
      rows = '{7'h24, 7'h51, 7'h46, 7'h68, 7'h78};
      rst();
      chk(mode, 32'h0);
      apb(1'b0, pmc_pkg::CTRL_OFS, 32'h0);
      chk(rd, pmc_pkg::CTRL_RST);
      apb(1'b0, pmc_pkg::STARTUP_OFS, 32'h0);
      chk(rd[15:0], pmc_pkg::STARTUP_RST);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, pmc_pkg::STARTUP_OFS, 32'h4);
      foreach (rows[i]) begin
         wdg_en <= rows[i][4];
         req(rows[i][6:5]);
         chk(mode, rows[i][3:1]);
         chk(cpu_en, rows[i][0]);
         if (rows[i][3:1] != 3'h2)
            chk(per_en, rows[i][0]);
         chk(frz, rows[i][4] && rows[i][3:1] == 3'h4);
         @(posedge clock_i);
         ack <= 1'b1; wake <= 4'h8;
         @(posedge clock_i);
         ack <= 1'b0; wake <= 4'h0;
         repeat (12) @(posedge clock_i);
         n = (rows[i][3:1] == 3'h3) ? 3 : 0;
         chk(mode, n);
         if (n == 3) begin
            rst();
            chk(mode, 32'h0);
            apb(1'b1, pmc_pkg::STARTUP_OFS, 32'h4);
         end
      end
      // Stop with watchdog on: frozen count, start-up wait, state kept
      wdg_en <= 1'b1;
      apb(1'b1, pmc_pkg::CTRL_OFS, 32'h32);
      req(2'h3);
      w0 = wcnt;
      repeat (5) @(posedge clock_i);
      chk(wcnt, w0);
      wake <= 4'h2;
      @(posedge clock_i);
      wake <= 4'h0;
      n = 0;
      repeat (30) begin
         @(posedge clock_i);
         if (mode == 3'h5 && cpu_en === 1'b0) n = n + 1;
      end
      chk(n, 4);
      chk(cpu_en, 1'b1);
      chk(wcnt != w0, 1'b1);
      apb(1'b0, pmc_pkg::CTRL_OFS, 32'h0);
      chk(rd, 32'h32);
      // Every clock source code
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, pmc_pkg::CTRL_OFS, 32'h30 | 32'(s) << 1);
         repeat (2) @(posedge clock_i);
         chk(src, s);
      end
      // Slow: divider 3 gives one cpu tick in four cycles
      apb(1'b1, pmc_pkg::CTRL_OFS, 32'h31);
      repeat (3) @(posedge clock_i);
      chk(mode, 32'h1);
      n = 0;
      repeat (40) begin
         @(posedge clock_i);
         n = n + int'(cpu_en);
      end
      chk(n, 10);
      // Low supply and external reset force run from wait-for-irq
      apb(1'b1, pmc_pkg::CTRL_OFS, 32'h30);
      req(2'h1);
      chk(mode, 32'h2);
      // Wait divider at reset 15: one irq and peripheral tick per 16
      n = 0;
      k = 0;
      repeat (32) begin
         @(posedge clock_i);
         n = n + int'(irq_en);
         k = k + int'(per_en);
         chk(cpu_en, 1'b0);
      end
      chk(n, 2);
      chk(k, 2);
      sup_low <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk({srst, mode}, 4'h8);
      sup_low <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk({srst, cpu_en}, 2'h1);
      req(2'h1);
      chk(mode, 32'h2);
      ext_n <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk({srst, mode}, 4'h8);
      ext_n <= 1'b1;
      end_sim();
   end
endmodule : pmc_top_tb
`default_nettype wire
